// ---- rtl/charge_current_foldback_ctrl.sv ----
`timescale 1ns/1ps
module charge_current_foldback_ctrl
    import charge_fold_pkg::*;
#(
    parameter int STEP_CNT     = STEP_CYCLES,
    parameter int DEBOUNCE_CNT = DEBOUNCE_CYCLES,
    parameter logic [10:0] STEP_MA = 11'h032
) (
    input  wire logic              core_clk_i,
    input  wire logic              rst_i,
    input  wire logic              reg_wr_i,
    input  wire logic [7:0]        reg_addr_i,
    input  wire logic [7:0]        reg_wdata_i,
    output logic      [7:0]        reg_rdata_o,
    input  wire logic              low_power_state_i,
    input  wire logic [10:0]       cc_program_ma_i,
    input  wire logic              tj_stage_zero_i,
    input  wire logic              tj_stage_zero_hys_i,
    input  wire logic              tj_stage_one_i,
    input  wire logic              tj_stage_one_hys_i,
    input  wire logic              tj_stage_two_i,
    input  wire logic              tj_stage_two_hys_i,
    input  wire logic              tj_125_i,
    input  wire logic              tj_120_i,
    input  wire logic              vin_above_reg_i,
    input  wire logic              vin_collapse_i,
    output logic [10:0]            charge_target_ma_o,
    output logic                   thermal_event_irq_o,
    output logic                   thermal_loop_sense_o,
    output logic                   input_event_irq_o,
    output logic                   input_power_loop_o,
    output logic [2:0]             thermal_stage_o,
    output logic [2:0]             input_regulation_voltage_o
);
    // ----------------------------------------
    // Comparator synchronisers
    // ----------------------------------------
    logic [9:0] cmp_raw, cmp_s1_q, cmp_s1_d, cmp_s2_q, cmp_s2_d;
    assign cmp_raw = {vin_collapse_i, vin_above_reg_i, tj_120_i, tj_125_i,
                      tj_stage_two_hys_i, tj_stage_two_i, tj_stage_one_hys_i,
                      tj_stage_one_i, tj_stage_zero_hys_i, tj_stage_zero_i};
    always_comb begin
        cmp_s1_d = cmp_raw;
        cmp_s2_d = cmp_s1_q;
    end
    always_ff @(posedge core_clk_i) begin
        cmp_s1_q <= rst_i ? 10'h000 : cmp_s1_d;
        cmp_s2_q <= rst_i ? 10'h000 : cmp_s2_d;
    end
    logic t0, t0h, t1, t1h, t2, t2h, t125, t120, v_ok, v_col;
    assign {v_col, v_ok, t120, t125, t2h, t2, t1h, t1, t0h, t0} = cmp_s2_q;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] temp_reg_q, temp_reg_d, in_reg_q, in_reg_d;
    always_comb begin
        temp_reg_d = temp_reg_q;
        in_reg_d   = in_reg_q;
        if (reg_wr_i && reg_addr_i == TEMP_REG_ADDR)
            temp_reg_d = reg_wdata_i & TEMP_REG_MASK;
        if (reg_wr_i && reg_addr_i == INPUT_REG_ADDR)
            in_reg_d = reg_wdata_i & INPUT_REG_MASK;
    end
    always_ff @(posedge core_clk_i) begin
        temp_reg_q <= rst_i ? TEMP_REG_RESET : temp_reg_d;
        in_reg_q   <= rst_i ? INPUT_REG_RESET : in_reg_d;
    end
    always_comb begin
        unique case (reg_addr_i)
            TEMP_REG_ADDR:  reg_rdata_o = temp_reg_q;
            INPUT_REG_ADDR: reg_rdata_o = in_reg_q;
            default:        reg_rdata_o = 8'h00;
        endcase
    end
    logic [1:0] jlim;
    logic       fb_en;
    assign jlim  = temp_reg_q[JLIM_LSB +: 2];
    assign fb_en = temp_reg_q[FB_EN_BIT];
    assign input_regulation_voltage_o = in_reg_q[VSEL_LSB +: VSEL_W];

    // ----------------------------------------
    // Thermal foldback state machine
    // ----------------------------------------
    // Stage comparators sit at base+15k; jlim picks which exist below 125
    thermal_state_t th_q, th_d;
    logic z_ok, o_ok, w_ok;
    assign z_ok = (jlim != JLIM_RESERVED);
    assign o_ok = (jlim == 2'h0) || (jlim == 2'h1);
    assign w_ok = (jlim == 2'h0);
    always_comb begin
        th_d = th_q;
        if (!fb_en || low_power_state_i) begin
            th_d = TH_FULL;
        end else begin
            unique case (th_q)
                TH_FULL: begin
                    if (t125) th_d = TH_HOT;
                    else if (z_ok && t0) th_d = TH_HALF;
                end
                TH_HALF: begin
                    if (t125) th_d = TH_HOT;
                    else if (o_ok && t1) th_d = TH_QUARTER;
                    else if (!z_ok || !t0h) th_d = TH_FULL;
                end
                TH_QUARTER: begin
                    if (t125) th_d = TH_HOT;
                    else if (w_ok && t2) th_d = TH_EIGHTH;
                    else if (!o_ok || !t1h) th_d = TH_HALF;
                end
                TH_EIGHTH: begin
                    if (t125) th_d = TH_HOT;
                    else if (!w_ok || !t2h) th_d = TH_QUARTER;
                end
                TH_HOT: begin
                    if (!t120) th_d = TH_EIGHTH;
                end
                default: th_d = TH_FULL;
            endcase
        end
    end
    always_ff @(posedge core_clk_i) begin
        th_q <= rst_i ? TH_FULL : th_d;
    end
    // Thermal state drives the status outputs and the foldback target; no fault path exists here
    assign thermal_event_irq_o  = (th_q != th_d);
    assign thermal_loop_sense_o = (th_q != TH_FULL);
    assign thermal_stage_o      = th_q;

    function automatic logic [10:0] clamp_min(input logic [10:0] v);
        return (v < MIN_CURRENT_MA) ? MIN_CURRENT_MA : v;
    endfunction

    logic [10:0] th_target;
    always_comb begin
        unique case (th_q)
            TH_HALF:    th_target = clamp_min(cc_program_ma_i >> 1);
            TH_QUARTER: th_target = clamp_min(cc_program_ma_i >> 2);
            TH_EIGHTH:  th_target = clamp_min(cc_program_ma_i >> 3);
            TH_HOT:     th_target = MIN_CURRENT_MA;
            default:    th_target = cc_program_ma_i;
        endcase
    end

    // ----------------------------------------
    // Input voltage regulation loop
    // ----------------------------------------
    logic [10:0] in_lim_q, in_lim_d;
    logic [22:0] step_q, step_d;
    logic [15:0] deb_q, deb_d;
    logic        ramp_q, ramp_d, irq_q, irq_d;
    logic        loop_stop;
    assign loop_stop = in_reg_q[LOOP_STOP_BIT];
    always_comb begin
        in_lim_d = in_lim_q;
        step_d   = step_q;
        ramp_d   = ramp_q;
        deb_d    = v_ok ? 16'h0000 : deb_q;
        irq_d    = 1'b0;
        if (!v_ok && deb_q != 16'(DEBOUNCE_CNT)) begin
            deb_d = deb_q + 16'h0001;
            irq_d = (deb_q == 16'(DEBOUNCE_CNT - 1));
        end
        if (loop_stop) begin
            in_lim_d = cc_program_ma_i;
            ramp_d   = 1'b0;
        end else if (v_col) begin
            in_lim_d = MIN_CURRENT_MA;
            ramp_d   = 1'b1;
            step_d   = 23'h000000;
        end else if (ramp_q) begin
            if (step_q == 23'(STEP_CNT - 1)) begin
                step_d = 23'h000000;
                if (!v_ok || in_lim_q >= cc_program_ma_i)
                    ramp_d = 1'b0;
                else
                    in_lim_d = in_lim_q + STEP_MA;
            end else begin
                step_d = step_q + 23'h000001;
            end
        end else if (!v_ok && in_lim_q > MIN_CURRENT_MA) begin
            in_lim_d = in_lim_q - 11'h001;
        end else if (in_lim_q < cc_program_ma_i && v_ok) begin
            in_lim_d = in_lim_q + 11'h001;
        end
    end
    always_ff @(posedge core_clk_i) begin
        in_lim_q <= rst_i ? IN_LIM_RESET : in_lim_d;
        step_q   <= rst_i ? 23'h000000 : step_d;
        deb_q    <= rst_i ? 16'h0000 : deb_d;
        ramp_q   <= rst_i ? 1'b0 : ramp_d;
        irq_q    <= rst_i ? 1'b0 : irq_d;
    end
    assign input_event_irq_o  = irq_q;
    assign input_power_loop_o = ramp_q || (in_lim_q < cc_program_ma_i);

    // ----------------------------------------
    // Final target
    // ----------------------------------------
    logic [10:0] tgt_q, tgt_d;
    always_comb begin
        tgt_d = cc_program_ma_i;
        if (th_target < tgt_d) tgt_d = th_target;
        if (in_lim_q < tgt_d) tgt_d = in_lim_q;
    end
    always_ff @(posedge core_clk_i) begin
        tgt_q <= rst_i ? 11'h000 : tgt_d;
    end
    assign charge_target_ma_o = tgt_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_hot_forces_min: assert property (@(posedge core_clk_i) disable iff (rst_i)
        th_q == TH_HOT |-> th_target == MIN_CURRENT_MA)
        else $error("hot stage target not minimum");
    a_lowpower_full: assert property (@(posedge core_clk_i) disable iff (rst_i)
        low_power_state_i |=> th_q == TH_FULL)
        else $error("foldback active in low power");
    a_disabled_full: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !fb_en |=> th_q == TH_FULL)
        else $error("foldback active while disabled");
    a_floor_min: assert property (@(posedge core_clk_i) disable iff (rst_i)
        th_q != TH_FULL |-> th_target >= MIN_CURRENT_MA)
        else $error("foldback below floor");
    a_collapse_min: assert property (@(posedge core_clk_i) disable iff (rst_i)
        v_col && !loop_stop |=> in_lim_q == MIN_CURRENT_MA)
        else $error("collapse not forced");
    a_event_on_change: assert property (@(posedge core_clk_i) disable iff (rst_i)
        thermal_event_irq_o |=> th_q != $past(th_q))
        else $error("event without state change");
    a_hot_exit: assert property (@(posedge core_clk_i) disable iff (rst_i)
        th_q == TH_HOT && t120 && fb_en && !low_power_state_i |=> th_q == TH_HOT)
        else $error("hot stage left early");
    a_target_min: assert property (@(posedge core_clk_i) disable iff (rst_i)
        1'b1 |=> tgt_q <= $past(in_lim_q) && tgt_q <= $past(th_target))
        else $error("target not minimum");
    a_jlim_reserved: assert property (@(posedge core_clk_i) disable iff (rst_i)
        jlim == JLIM_RESERVED && th_q == TH_FULL && !t125 |=> th_q == TH_FULL)
        else $error("reserved code folded");
    c_half: cover property (@(posedge core_clk_i) th_q == TH_FULL ##1 th_q == TH_HALF);
    c_hot: cover property (@(posedge core_clk_i) th_q == TH_HOT);
    c_collapse: cover property (@(posedge core_clk_i) v_col ##1 ramp_q);
    c_input_irq: cover property (@(posedge core_clk_i) input_event_irq_o);
    c_ramp_stop: cover property (@(posedge core_clk_i) ramp_q ##1 !ramp_q);

    // ----------------------------------------
    // Thermal stage transitions
    // ----------------------------------------
    // Each stage is checked one edge at a time; a skipped quarter stage must never follow the half stage
    a_half_entry: assert property (@(posedge core_clk_i) disable iff (rst_i)
        th_q == TH_FULL && fb_en && !low_power_state_i && z_ok && t0 && !t125
        |=> th_q == TH_HALF) else $error("half stage not entered");
    a_half_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
        th_q == TH_HALF && fb_en && !low_power_state_i && !t125 && !(o_ok && t1)
        && z_ok && t0h |=> th_q == TH_HALF) else $error("half stage left early");
    a_quarter_entry: assert property (@(posedge core_clk_i) disable iff (rst_i)
        th_q == TH_HALF && fb_en && !low_power_state_i && !t125 && o_ok && t1
        |=> th_q == TH_QUARTER) else $error("quarter stage not entered");
    a_quarter_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
        th_q == TH_QUARTER && fb_en && !low_power_state_i && !t125 && !(w_ok && t2)
        && o_ok && t1h |=> th_q == TH_QUARTER) else $error("quarter stage left early");
    a_quarter_exit: assert property (@(posedge core_clk_i) disable iff (rst_i)
        th_q == TH_QUARTER && fb_en && !low_power_state_i && !t125 && !(w_ok && t2)
        && (!o_ok || !t1h) |=> th_q == TH_HALF) else $error("quarter stage not left");
    a_eighth_entry: assert property (@(posedge core_clk_i) disable iff (rst_i)
        th_q == TH_QUARTER && fb_en && !low_power_state_i && !t125 && w_ok && t2
        |=> th_q == TH_EIGHTH) else $error("eighth stage not entered");
    a_eighth_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
        th_q == TH_EIGHTH && fb_en && !low_power_state_i && !t125 && w_ok && t2h
        |=> th_q == TH_EIGHTH) else $error("eighth stage left early");
    a_hot_entry: assert property (@(posedge core_clk_i) disable iff (rst_i)
        th_q != TH_HOT && fb_en && !low_power_state_i && t125
        |=> th_q == TH_HOT) else $error("hot stage not entered");
    a_hot_release: assert property (@(posedge core_clk_i) disable iff (rst_i)
        th_q == TH_HOT && fb_en && !low_power_state_i && !t120
        |=> th_q == TH_EIGHTH) else $error("hot stage not released");
    a_stage_skip: assert property (@(posedge core_clk_i) disable iff (rst_i)
        th_q == TH_HALF && !o_ok |=> th_q != TH_QUARTER)
        else $error("omitted stage entered");

    // ----------------------------------------
    // Input loop and registers
    // ----------------------------------------
    // While ramping without collapse or loop stop, limit only moves on a step boundary, so a slow source has time to recover
    a_ramp_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ramp_q && !loop_stop && !v_col && step_q != 23'(STEP_CNT - 1)
        |=> in_lim_q == $past(in_lim_q)) else $error("ramp moved between steps");
    a_ramp_stop: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ramp_q && !loop_stop && !v_col && step_q == 23'(STEP_CNT - 1) && !v_ok
        |=> !ramp_q) else $error("ramp kept climbing with input low");
    a_irq_single: assert property (@(posedge core_clk_i) disable iff (rst_i)
        input_event_irq_o |=> !input_event_irq_o)
        else $error("input event longer than one cycle");
    a_stop_pass: assert property (@(posedge core_clk_i) disable iff (rst_i)
        loop_stop |=> in_lim_q == $past(cc_program_ma_i))
        else $error("stopped loop still limits");
    a_reserved_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (temp_reg_q & ~TEMP_REG_MASK) == 8'h00 && (in_reg_q & ~INPUT_REG_MASK) == 8'h00)
        else $error("reserved register bit set");
endmodule

// ---- rtl/charge_fold_pkg.sv ----
package charge_fold_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] TEMP_REG_ADDR   = 8'h92;
    localparam logic [7:0] INPUT_REG_ADDR  = 8'h95;
    localparam logic [7:0] TEMP_REG_RESET  = 8'h05;
    localparam logic [7:0] INPUT_REG_RESET = 8'h00;
    localparam logic [7:0] TEMP_REG_MASK   = 8'hBF;
    localparam logic [7:0] INPUT_REG_MASK  = 8'h3F;
    localparam int FB_EN_BIT   = 7;
    localparam int JLIM_LSB    = 2;
    localparam int VSEL_LSB    = 0;
    localparam int VSEL_W      = 3;
    localparam int LOOP_STOP_BIT = 5;
    localparam logic [1:0] JLIM_RESERVED = 2'h3;
    // ----------------------------------------
    // Currents and timing
    // ----------------------------------------
    localparam int CUR_W       = 11;
    localparam logic [10:0] MIN_CURRENT_MA = 11'h064;
    localparam logic [10:0] IN_LIM_RESET   = 11'h7FF;
    localparam int CLK_HZ      = 50_000_000;
    localparam int STEP_MS     = 10;
    localparam int STEP_CYCLES = CLK_HZ / 1000 * STEP_MS;
    localparam int DEBOUNCE_US = 10;
    localparam int DEBOUNCE_CYCLES = CLK_HZ / 1_000_000 * DEBOUNCE_US;
    typedef enum logic [2:0] {
        TH_FULL, TH_HALF, TH_QUARTER, TH_EIGHTH, TH_HOT
    } thermal_state_t;
endpackage

// ---- tb/junction_sense_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Die and input comparators
// ----------------------------------------
module junction_sense_model (
    input  wire logic [1:0] jlim_sel_i,
    input  int              temp_c_i,
    input  int              vin_mv_i,
    input  int              vset_mv_i,
    output logic      [5:0] tj_stage_o,
    output logic            tj_125_o,
    output logic            tj_120_o,
    output logic            vin_above_o,
    output logic            vin_collapse_o
);
    int base;
    always_comb begin
        // Comparators exist for every stage; omitting stages is the controller's job
        base = 80 + 15 * int'(jlim_sel_i);
        for (int k = 0; k < 3; k++) begin
            tj_stage_o[2*k]   = temp_c_i >= base + 15 * k;
            tj_stage_o[2*k+1] = temp_c_i >= base + 15 * k - 5;
        end
        tj_125_o       = temp_c_i >= 125;
        tj_120_o       = temp_c_i >= 120;
        vin_above_o    = vin_mv_i > vset_mv_i;
        vin_collapse_o = vin_mv_i < vset_mv_i - 200;
    end
endmodule

// ---- tb/test_charge_current_foldback_ctrl.sv ----
`timescale 1ns/1ps
module test_charge_current_foldback_ctrl;
    import charge_fold_pkg::*;
    typedef struct {int code; int temp; int stg;} row_t;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        wr = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        lps = 1'b0;
    logic [1:0]  jsel = 2'h1;
    logic [7:0]  rdata;
    logic [10:0] tgt;
    logic [2:0]  stage, vsel;
    logic [5:0]  tjs;
    logic        t125, t120, vab, vcol, irq_t, sense, irq_i, iloop;
    int          temp = 25, vin = 5000, vset = 3900, n;
    int          errors = 0, cmp_count = 0, tcount = 0, icount = 0;
    row_t        rows [22] = '{'{0,25,0}, '{0,80,1}, '{0,77,1}, '{0,95,2}, '{0,110,3},
        '{0,125,4}, '{0,121,4}, '{0,119,3}, '{0,104,2}, '{0,89,1}, '{0,74,0},
        '{1,94,0}, '{1,95,1}, '{1,110,2}, '{1,124,2}, '{1,104,1}, '{1,20,0},
        '{2,109,0}, '{2,110,1}, '{2,124,1}, '{2,104,0}, '{3,125,4}};
    always #10 clk = ~clk;
    always @(posedge clk) begin
        if (irq_t === 1'b1) tcount++;
        if (irq_i === 1'b1) icount++;
    end
    junction_sense_model u_junction_sense_model (.jlim_sel_i(jsel), .temp_c_i(temp),
        .vin_mv_i(vin), .vset_mv_i(vset), .tj_stage_o(tjs), .tj_125_o(t125),
        .tj_120_o(t120), .vin_above_o(vab), .vin_collapse_o(vcol));
    charge_current_foldback_ctrl #(.STEP_CNT(20), .DEBOUNCE_CNT(4)) u_charge_current_foldback_ctrl (
        .core_clk_i(clk), .rst_i(rst), .reg_wr_i(wr), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .low_power_state_i(lps),
        .cc_program_ma_i(11'h3E8), .tj_stage_zero_i(tjs[0]), .tj_stage_zero_hys_i(tjs[1]),
        .tj_stage_one_i(tjs[2]), .tj_stage_one_hys_i(tjs[3]), .tj_stage_two_i(tjs[4]),
        .tj_stage_two_hys_i(tjs[5]), .tj_125_i(t125), .tj_120_i(t120),
        .vin_above_reg_i(vab), .vin_collapse_i(vcol), .charge_target_ma_o(tgt),
        .thermal_event_irq_o(irq_t), .thermal_loop_sense_o(sense),
        .input_event_irq_o(irq_i), .input_power_loop_o(iloop),
        .thermal_stage_o(stage), .input_regulation_voltage_o(vsel));
    // ----------------------------------------
    // Access and compare tasks
    // ----------------------------------------
    task automatic cmp(input logic [10:0] got, input logic [10:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        wt(1);
        cmp({3'h0, rdata}, {3'h0, e});
    endtask
    // Waits for the next ramp step, bounded well past one step period
    task automatic next_step(input logic [10:0] e);
        n = 0;
        do begin
            wt(1);
            n++;
        end while (tgt === e - 11'h032 && n < 60);
        cmp(tgt, e);
    endtask
    function automatic logic [10:0] exp_tgt(input int s);
        int v;
        v = (s == 4) ? 100 : 1000 >> s;
        return (v < 100) ? 11'h064 : 11'(v);
    endfunction
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        reg_rd(8'h92, 8'h05);
        reg_rd(8'h95, 8'h00);
        reg_rd(8'h93, 8'h00);
        reg_wr(8'h92, 8'hFF);
        reg_rd(8'h92, 8'hBF);
        reg_wr(8'h95, 8'hFF);
        reg_rd(8'h95, 8'h3F);
        jsel <= 2'h3;
        foreach (rows[i]) begin
            if (i == 0 || rows[i].code != rows[i-1].code) begin
                reg_wr(8'h92, 8'h80 | 8'(rows[i].code << 2));
                jsel <= 2'(rows[i].code);
            end
            @(posedge clk);
            temp <= rows[i].temp;
            wt(6);
            cmp({8'h00, stage}, 11'(rows[i].stg));
            cmp(tgt, exp_tgt(rows[i].stg));
            cmp({10'h000, sense}, {10'h000, rows[i].stg != 0});
        end
        cmp(11'(tcount), 11'h00F);
        @(posedge clk);
        lps <= 1'b1;
        wt(6);
        cmp(tgt, 11'h3E8);
        @(posedge clk);
        lps <= 1'b0;
        wt(6);
        cmp(tgt, 11'h064);
        reg_wr(8'h92, 8'h0C);
        temp <= 20;
        wt(6);
        cmp(tgt, 11'h3E8);
        reg_wr(8'h95, 8'h06);
        vset <= 3900 + 100 * 6;
        wt(2);
        cmp({8'h00, vsel}, 11'h006);
        @(posedge clk);
        vin <= 4200;
        wt(6);
        cmp(tgt, 11'h064);
        cmp({10'h000, iloop}, 11'h001);
        wt(6);
        cmp({10'h000, icount != 0}, 11'h001);
        @(posedge clk);
        vin <= 5000;
        next_step(11'h096);
        next_step(11'h0C8);
        @(posedge clk);
        vin <= 4400;
        wt(50);
        // Ramp must stop climbing once the input no longer sits above the setpoint
        cmp({10'h000, tgt < 11'h0FA}, 11'h001);
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        give_verdict();
    end
endmodule
